/* File: rtl/terec_params.svh */
// Purpose: constants of the timer output recovery block
// Assumes: included by its bare name
// Notes:   offsets are byte addresses on the plain register port
`ifndef TEREC_PARAMS_SVH
`define TEREC_PARAMS_SVH

// register offsets
`define TEREC_OFS_START    8'h00
`define TEREC_OFS_MODE     8'h04
`define TEREC_OFS_PINIO    8'h08
`define TEREC_OFS_OUTEN    8'h0C
`define TEREC_OFS_LEVEL    8'h10
`define TEREC_OFS_FUNC     8'h14
`define TEREC_OFS_PORTDAT  8'h18
`define TEREC_OFS_PORTDIR  8'h1C
`define TEREC_OFS_STATUS   8'h20
`define TEREC_OFS_CMP0     8'h40

// field positions
`define TEREC_LVL_CYCEN    0
`define TEREC_LVL_CPINIT   1
`define TEREC_LVL_RSINIT   2
`define TEREC_PINIO_MATCH  10

// fixed pin roles of the channel 3/4 group
`define TEREC_PIN_CYCLIC   6
`define TEREC_PIN_SPARE    7
`define TEREC_PIN_POS      8
`define TEREC_PIN_NEG      9

// pin masks
`define TEREC_MASK_BSIDE   10'h2AA
`define TEREC_MASK_CYCREG  10'h015

// reset values
`define TEREC_RST_WAVE     10'h000
`define TEREC_RST_CMP      32'h0000_0000

`endif

/* File: rtl/terec_pkg.sv */
// Purpose: shared types of the timer output recovery block
// Assumes: nothing
// Notes:   mode codes 6 and 7 are illegal and are refused
package terec_pkg;

  typedef enum logic [2:0] {
    NORMAL,
    PWM1,
    PWM2,
    PHASE,
    COMP,
    RSYNC
  } terec_mode_t;

endpackage

/* File: rtl/terec_match_counter.sv */
// Purpose: free counter with cycle wrap and compare match pulse
// Assumes: cycle and compare are steady while running
// Notes:   the counter holds its value when stopped, so a resume continues
`timescale 1ns/1ns
module terec_match_counter #(
  parameter int CW = 16
) (
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire logic          run,
  input  wire logic [CW-1:0] cycle,
  input  wire logic [CW-1:0] compare,
  output logic               match
);

  logic [CW-1:0] count;
  wire           atCycle = (count == cycle);
  wire           atCmp   = (count == compare);

  // count up and wrap at the cycle value
  always_ff @(posedge clock) begin
    if (!resetn) begin
      count <= '0;
      match <= 1'b0;
    end else begin
      match <= run & atCmp;
      if (run) begin
        count <= atCycle ? '0 : count + 1'b1;
      end
    end
  end

endmodule // terec_match_counter

/* File: rtl/terec_output_recovery.sv */
// Purpose: output pin control of a five channel timer during error recovery
// Assumes: register port is synchronous, one strobe per cycle
// Notes:   pins 6..9 form the group used by the paired PWM modes
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
`include "terec_params.svh"

////////////////////////////////////////////////////////////////////////////////
module terec_output_recovery #(
  parameter int CW = 16
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  output logic      [9:0]  pinOut,
  output logic      [9:0]  pinOutEnN
);

  localparam int NCH = 5;
  localparam int NP  = 2 * NCH;

  ////////////////////////////////////////////////////////////////////////////////
  // register map, byte offsets on the plain port
  //   start      count run bits, one per channel
  //   mode       operating mode, codes 6 and 7 are ignored
  //   pin io     [9:0] init levels loaded at once, [19:10] match levels
  //   out enable [3:0] gates pins 6..9 of the paired group
  //   level ctl  cyclic enable, paired init levels
  //   function   1 hands a pin to the timer, 0 to the general port
  //   port data  level a port pin shows while it drives
  //   port dir   1 lets a port pin drive, 0 leaves it released
  //   status     present waveform, readable whatever the pin function
  //   compare    one word per channel, compare low half, cycle high half
  //
  // software parks pins as ports before it stops a count; the block does
  // not enforce that order, it only keeps the waveform consistent so the
  // port to timer hand-back shows the documented level

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic [NCH-1:0]          countRun;
  terec_pkg::terec_mode_t  mode;
  logic [NP-1:0]           matchLvl;
  logic [3:0]              outEnable;
  logic [2:0]              levelCtl;
  logic [NP-1:0]           pinFunc;
  logic [NP-1:0]           portData;
  logic [NP-1:0]           portDir;
  logic [NP-1:0]           wave;
  logic [NP-1:0]           next_wave;
  logic [CW-1:0]           cmpVal [NCH];
  logic [CW-1:0]           cycVal [NCH];
  logic [NCH-1:0]          match;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  wire        wrStart   = regWrite & (regAddr == `TEREC_OFS_START);
  wire        wrMode    = regWrite & (regAddr == `TEREC_OFS_MODE);
  wire        wrPinIo   = regWrite & (regAddr == `TEREC_OFS_PINIO);
  wire        wrOutEn   = regWrite & (regAddr == `TEREC_OFS_OUTEN);
  wire        wrLevel   = regWrite & (regAddr == `TEREC_OFS_LEVEL);
  wire        wrFunc    = regWrite & (regAddr == `TEREC_OFS_FUNC);
  wire        wrPortDat = regWrite & (regAddr == `TEREC_OFS_PORTDAT);
  wire        wrPortDir = regWrite & (regAddr == `TEREC_OFS_PORTDIR);
  wire        inCmpWin  = (regAddr >= `TEREC_OFS_CMP0) &
                          (regAddr <  `TEREC_OFS_CMP0 + 8'(4 * NCH)) &
                          (regAddr[1:0] == 2'b00);
  wire [7:0]  cmpOff    = regAddr - `TEREC_OFS_CMP0;
  wire [2:0]  cmpIdx    = cmpOff[4:2];

  ////////////////////////////////////////////////////////////////////////////////
  // mode decode

  wire [2:0]  newModeRaw = regWdata[2:0];
  wire        modeLegal  = (newModeRaw <= 3'h5);
  terec_pkg::terec_mode_t newMode;
  assign newMode = terec_pkg::terec_mode_t'(newModeRaw);

  wire        modeEv     = wrMode & modeLegal;
  wire        groupMode  = (mode == terec_pkg::COMP) | (mode == terec_pkg::RSYNC);
  wire        groupRun   = countRun[3] | countRun[4];
  wire        groupStop  = wrStart & groupRun & ~(regWdata[3] | regWdata[4]);
  wire        toLowMode  = (newMode == terec_pkg::NORMAL) | (newMode == terec_pkg::PWM1);
  wire        cycEnable  = levelCtl[`TEREC_LVL_CYCEN];
  wire        compInit   = levelCtl[`TEREC_LVL_CPINIT];
  wire        rsInit     = levelCtl[`TEREC_LVL_RSINIT];
  // the match flop is one cycle late; a pulse that lands after the stop
  // write must not toggle the stop levels, so only live channels count
  wire [NCH-1:0] liveMatch = match & countRun;
  wire        groupMatch = groupMode & (liveMatch[3] | liveMatch[4]);

  // the mode change effects only act once the group counter is idle;
  // a mode write while running would fight the waveform logic
  wire        compExitLow = modeEv & ~groupRun & (mode == terec_pkg::COMP) & toLowMode;
  wire        rsExitLow   = modeEv & ~groupRun & (mode == terec_pkg::RSYNC) & toLowMode;
  wire        rsToComp    = modeEv & ~groupRun & (mode == terec_pkg::RSYNC) &
                            (newMode == terec_pkg::COMP);

  ////////////////////////////////////////////////////////////////////////////////
  // pin init masking

  // a zero bit shields the pin from a pin init write
  wire [NP-1:0] maskPwm1 = ~`TEREC_MASK_BSIDE;
  wire [NP-1:0] maskPwm2 = ~`TEREC_MASK_CYCREG;
  wire [NP-1:0] initMask = (mode == terec_pkg::PWM1) ? maskPwm1 :
                           (mode == terec_pkg::PWM2) ? maskPwm2 :
                           {NP{1'b1}};
  wire [NP-1:0] initLvl  = regWdata[NP-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // per channel counters

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : gCh
      terec_match_counter #(
        .CW      (CW)
      ) uCnt (
        .clock   (clock),
        .resetn  (resetn),
        .run     (countRun[ch]),
        .cycle   (cycVal[ch]),
        .compare (cmpVal[ch]),
        .match   (match[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // waveform next state
  // later assignments take priority: software events beat a same cycle match
  //
  // order of precedence, lowest first:
  //   compare match of a running channel
  //   pin init write, masked by the mode
  //   count stop inside a paired mode
  //   mode change out of a stopped paired mode
  // a mode change while the group runs changes no pin level except the inactive level of a disabled
  // negative phase pin, which keeps a careless write from glitching the power stage mid-period

  always_comb begin
    next_wave = wave;
    // single channel compare behaviour
    for (int p = 0; p < NP; p++) begin
      if (liveMatch[p / 2] && !(groupMode && p >= `TEREC_PIN_CYCLIC)) begin
        next_wave[p] = matchLvl[p];
      end
    end
    // paired waveform of the channel 3/4 group
    if (groupMatch) begin
      next_wave[`TEREC_PIN_POS] = ~wave[`TEREC_PIN_POS];
      next_wave[`TEREC_PIN_NEG] = wave[`TEREC_PIN_POS];
      if (cycEnable) begin
        next_wave[`TEREC_PIN_CYCLIC] = ~wave[`TEREC_PIN_CYCLIC];
      end
    end
    // pin initialisation
    if (wrPinIo) begin
      next_wave = (next_wave & ~initMask) | (initLvl & initMask);
    end
    // count stop inside a paired mode
    if (groupStop && mode == terec_pkg::COMP) begin
      next_wave[`TEREC_PIN_CYCLIC] = compInit;
      next_wave[`TEREC_PIN_POS]    = compInit;
      next_wave[`TEREC_PIN_NEG]    = ~compInit;
    end
    if (groupStop && mode == terec_pkg::RSYNC) begin
      next_wave[`TEREC_PIN_CYCLIC] = rsInit;
      next_wave[`TEREC_PIN_POS]    = rsInit;
      next_wave[`TEREC_PIN_NEG]    = ~rsInit;
    end
    // mode change out of a stopped paired mode
    if (compExitLow) begin
      next_wave = '0;
    end
    if (rsExitLow) begin
      next_wave[`TEREC_PIN_CYCLIC] = 1'b0;
      next_wave[`TEREC_PIN_SPARE]  = 1'b0;
      next_wave[`TEREC_PIN_POS]    = 1'b0;
      next_wave[`TEREC_PIN_NEG]    = 1'b1;
    end
    if (rsToComp) begin
      next_wave[`TEREC_PIN_CYCLIC] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin level selection

  // disabled group pins sit at the inactive level, high only for the
  // negative phase of a paired mode so the power stage stays off
  logic [NP-1:0] inactive;
  logic [NP-1:0] gateEn;
  always_comb begin
    inactive = '0;
    inactive[`TEREC_PIN_NEG] = groupMode;
    gateEn = {NP{1'b1}};
    gateEn[`TEREC_PIN_NEG:`TEREC_PIN_CYCLIC] = outEnable;
  end

  wire [NP-1:0] timerLvl  = (wave & gateEn) | (inactive & ~gateEn);
  wire [NP-1:0] next_pin  = (timerLvl & pinFunc) | (portData & ~pinFunc);
  wire [NP-1:0] next_enN  = ~(pinFunc | portDir);

  ////////////////////////////////////////////////////////////////////////////////
  // read mux

  logic [31:0] readVal;
  always_comb begin
    readVal = 32'h0000_0000;
    unique case (regAddr)
      `TEREC_OFS_START:   readVal[NCH-1:0] = countRun;
      `TEREC_OFS_MODE:    readVal[2:0]     = mode;
      `TEREC_OFS_PINIO:   readVal[19:10]   = matchLvl;
      `TEREC_OFS_OUTEN:   readVal[3:0]     = outEnable;
      `TEREC_OFS_LEVEL:   readVal[2:0]     = levelCtl;
      `TEREC_OFS_FUNC:    readVal[NP-1:0]  = pinFunc;
      `TEREC_OFS_PORTDAT: readVal[NP-1:0]  = portData;
      `TEREC_OFS_PORTDIR: readVal[NP-1:0]  = portDir;
      `TEREC_OFS_STATUS:  readVal[NP-1:0]  = wave;
      default: begin
        if (inCmpWin) begin
          readVal = {cycVal[cmpIdx], cmpVal[cmpIdx]};
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control registers

  // count start is a plain write; software orders it against mode changes
  always_ff @(posedge clock) begin
    if (!resetn) begin
      countRun <= '0;
      mode     <= terec_pkg::NORMAL;
    end else begin
      if (wrStart) begin
        countRun <= regWdata[NCH-1:0];
      end
      if (modeEv) begin
        mode <= newMode;
      end
    end
  end

  // pin io, enable and level control
  always_ff @(posedge clock) begin
    if (!resetn) begin
      matchLvl  <= '0;
      outEnable <= '0;
      levelCtl  <= '0;
    end else begin
      if (wrPinIo) begin
        matchLvl <= regWdata[`TEREC_PIN_NEG + `TEREC_PINIO_MATCH:`TEREC_PINIO_MATCH];
      end
      if (wrOutEn) begin
        outEnable <= regWdata[3:0];
      end
      if (wrLevel) begin
        levelCtl <= regWdata[2:0];
      end
    end
  end

  // pin function: zero selects general port, kept high-impedance until set
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pinFunc  <= '0;
      portData <= '0;
      portDir  <= '0;
    end else begin
      if (wrFunc) begin
        pinFunc <= regWdata[NP-1:0];
      end
      if (wrPortDat) begin
        portData <= regWdata[NP-1:0];
      end
      if (wrPortDir) begin
        portDir <= regWdata[NP-1:0];
      end
    end
  end

  // compare and cycle values, one word per channel
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        cmpVal[i] <= '0;
        cycVal[i] <= '0;
      end
    end else if (regWrite && inCmpWin) begin
      cmpVal[cmpIdx] <= regWdata[CW-1:0];
      cycVal[cmpIdx] <= regWdata[16+CW-1:16];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output flops

  // every pin output comes from a flop, one cycle behind its cause
  // pins thus lag the status word by one cycle; the trade buys clean
  // edges at the power stage for a single cycle of latency
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wave      <= `TEREC_RST_WAVE;
      pinOut    <= '0;
      pinOutEnN <= '1;
      regRdata  <= 32'h0000_0000;
    end else begin
      wave      <= next_wave;
      pinOut    <= next_pin;
      pinOutEnN <= next_enN;
      regRdata  <= regRead ? readVal : 32'h0000_0000;
    end
  end

endmodule // terec_output_recovery

/* File: testbench/terec_power_stage.sv */
// Purpose: gate driver stage seen by the ten timer pins
// Assumes: every gate input has a pull-down
// Notes:   a released pin never shows its last level
`timescale 1ns/1ns
module terec_power_stage (
  input  wire logic [9:0] pinOut,
  input  wire logic [9:0] pinOutEnN,
  output logic      [9:0] padLevel
);
  // undriven inputs fall to the pull-down, so a floating pin reads as off
  assign padLevel = pinOut & ~pinOutEnN;
endmodule // terec_power_stage

/* File: testbench/terec_output_recovery_asserts.sv */
// Purpose: port checks of the timer output recovery block
// Assumes: software settings are tracked from the register strobes
// Notes:   status reads expose the waveform for the stop checks
`timescale 1ns/1ns
`include "terec_params.svh"
module terec_output_recovery_asserts #(
  parameter int CW = 16
) (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic [9:0]  pinOut,
  input wire logic [9:0]  pinOutEnN
);
  terec_pkg::terec_mode_t modeQ;
  logic [4:0]             startQ;
  logic [9:0]             funcQ;
  logic [3:0]             outQ;
  logic [2:0]             lvlQ;
  ////////////////////////////////////////
  // shadow of the settings; 4'h5 means enables not yet written
  always_ff @(posedge clock) begin
    if (!resetn) begin
      modeQ <= terec_pkg::NORMAL;
      startQ <= 5'h00;
      funcQ <= 10'h000;
      outQ <= 4'h5;
      lvlQ <= 3'h0;
    end else if (regWrite) begin
      if (regAddr == `TEREC_OFS_MODE && regWdata[2:0] < 3'd6) modeQ <= terec_pkg::terec_mode_t'(regWdata[2:0]);
      if (regAddr == `TEREC_OFS_START) startQ <= regWdata[4:0];
      if (regAddr == `TEREC_OFS_FUNC) funcQ <= regWdata[9:0];
      if (regAddr == `TEREC_OFS_OUTEN) outQ <= regWdata[3:0];
      if (regAddr == `TEREC_OFS_LEVEL) lvlQ <= regWdata[2:0];
    end
  end
  // decoded events
  wire stRd = regRead && regAddr == `TEREC_OFS_STATUS;
  wire ioWr = regWrite && regAddr == `TEREC_OFS_PINIO;
  wire mdWr = regWrite && regAddr == `TEREC_OFS_MODE;
  wire idle = startQ[4:3] == 2'b00;
  wire pair = modeQ == terec_pkg::COMP || modeQ == terec_pkg::RSYNC;
  wire initB = (modeQ == terec_pkg::COMP) ? lvlQ[1] : lvlQ[2];
  wire stop = regWrite && regAddr == `TEREC_OFS_START && regWdata[4:3] == 2'b00 && !idle && pair;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  reset_pins_a: assert property (disable iff (1'b0) !resetn |=> pinOut == 10'h000 && pinOutEnN == 10'h3FF)
    else $error("pins not quiet after reset");
  read_idle_a: assert property (!regRead |=> regRdata == 32'h0000_0000) else $error("read data outside read slot");
  pwm1_bside_a: assert property (ioWr && idle && modeQ == terec_pkg::PWM1 ##1 !regWrite
    |=> (pinOut & 10'h2AA) == ($past(pinOut) & 10'h2AA)) else $error("pin init moved a B pin");
  pwm2_cycle_a: assert property (ioWr && idle && modeQ == terec_pkg::PWM2 ##1 !regWrite
    |=> (pinOut & 10'h015) == ($past(pinOut) & 10'h015)) else $error("pin init moved a cycle pin");
  stop_init_a: assert property (stop ##1 !regWrite ##1 stRd
    |=> regRdata[8] == initB && regRdata[6] == initB && regRdata[9] == !initB) else $error("stop level wrong");
  comp_exit_a: assert property (mdWr && idle && modeQ == terec_pkg::COMP && regWdata[2:1] == 2'b00
    ##1 !regWrite ##1 stRd |=> regRdata[9:0] == 10'h000) else $error("comp exit not low");
  rsync_exit_a: assert property (mdWr && idle && modeQ == terec_pkg::RSYNC && regWdata[2:1] == 2'b00
    ##1 !regWrite ##1 stRd |=> regRdata[9:8] == 2'b10) else $error("rsync exit phases wrong");
  cyclic_low_a: assert property (mdWr && idle && modeQ == terec_pkg::RSYNC && regWdata[2:0] == 3'd4
    ##1 !regWrite ##1 stRd |=> !regRdata[6]) else $error("cyclic pin not low");
  status_pins_a: assert property (stRd && funcQ == 10'h3FF && outQ == 4'hF
    |=> regRdata[9:0] == pinOut && pinOutEnN == 10'h000) else $error("pins differ from waveform");
  group_off_a: assert property (stRd && funcQ == 10'h3FF && outQ == 4'h0
    |=> pinOut[8:6] == 3'b000 && pinOut[9] == pair) else $error("disabled pin not inactive");
  // main scenarios
  cover property (stop);
  cover property (ioWr && modeQ == terec_pkg::PWM2);
  cover property (stRd && outQ == 4'h0);
endmodule // terec_output_recovery_asserts
bind terec_output_recovery terec_output_recovery_asserts #(.CW(CW)) chk_u (.clock(clock), .resetn(resetn),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .pinOut(pinOut), .pinOutEnN(pinOutEnN));

/* File: testbench/testbench.sv */
// Purpose: error recovery sequences on the timer output block
// Assumes: register effects reach the pins two edges after the write
// Notes:   the waveform is read back through the status word
`timescale 1ns/1ns
`include "terec_params.svh"
module testbench;
  logic        clock;
  logic        resetn;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic [9:0]  pinOut;
  logic [9:0]  pinOutEnN;
  logic [9:0]  padLevel;
  logic [31:0] rdv;
  int          failures;
  int          checks;
  terec_output_recovery #(.CW(16)) dut_u (.clock(clock), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .pinOut(pinOut), .pinOutEnN(pinOutEnN));
  terec_power_stage stage_u (.pinOut(pinOut), .pinOutEnN(pinOutEnN), .padLevel(padLevel));
  ////////////////////////////////////////
  // bus cycles; a gap cycle follows every strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 rdv = regRdata;
  endtask
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chs(input string n, input logic [9:0] m, input logic [9:0] e);
    rd(`TEREC_OFS_STATUS);
    chk(n, e, rdv[9:0] & m);
  endtask
  // bounded wait for a pin edge; waveform pairs stay complementary
  task automatic waitpin(input int b, input logic v, input string n);
    #1;
    for (int i = 0; i < 60 && pinOut[b] === v; i++) begin
      @(posedge clock);
      #1;
    end
    chk(n, {9'h000, !v}, {9'h000, pinOut[b]});
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    #1;
    chk("pins", 10'h000, pinOut);
    chk("enables", 10'h3FF, pinOutEnN);
    chk("pads", 10'h000, padLevel);
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC);
    chk("unmapped", 10'h000, {9'h000, |rdv});
  endtask
  task automatic t_normal();
    wr(`TEREC_OFS_OUTEN, 32'h0000_000F);
    wr(`TEREC_OFS_FUNC, 32'h0000_03FF);
    wr(`TEREC_OFS_CMP0, 32'h0008_0003);
    wr(`TEREC_OFS_PINIO, 32'h0000_0001);
    chs("init high", 10'h001, 10'h001);
    wr(`TEREC_OFS_START, 32'h0000_0001);
    waitpin(0, 1'b1, "match low");
    wr(`TEREC_OFS_PORTDAT, 32'h0000_0001);
    wr(`TEREC_OFS_PORTDIR, 32'h0000_03FF);
    wr(`TEREC_OFS_FUNC, 32'h0000_0000);
    wr(`TEREC_OFS_START, 32'h0000_0000);
    repeat (2) @(posedge clock);
    #1 chk("port pads", 10'h001, padLevel);
  endtask
  task automatic t_modes();
    wr(`TEREC_OFS_FUNC, 32'h0000_03FF);
    wr(`TEREC_OFS_PINIO, 32'h0000_0000);
    wr(`TEREC_OFS_MODE, 32'h0000_0001);
    wr(`TEREC_OFS_MODE, 32'h0000_0007);
    wr(`TEREC_OFS_PINIO, 32'h0000_03FF);
    chs("pwm1 init", 10'h3FF, 10'h155);
    wr(`TEREC_OFS_MODE, 32'h0000_0002);
    wr(`TEREC_OFS_PINIO, 32'h0000_0000);
    chs("pwm2 init", 10'h3FF, 10'h015);
    wr(`TEREC_OFS_MODE, 32'h0000_0003);
    wr(`TEREC_OFS_PINIO, 32'h0000_02AA);
    chs("phase init", 10'h3FF, 10'h2AA);
  endtask
  task automatic t_comp();
    wr(`TEREC_OFS_OUTEN, 32'h0000_0000);
    wr(`TEREC_OFS_LEVEL, 32'h0000_0003);
    wr(`TEREC_OFS_MODE, 32'h0000_0004);
    wr(`TEREC_OFS_FUNC, 32'h0000_03FF);
    chs("comp entry", 10'h3FF, 10'h2AA);
    chk("group off", 10'h200, pinOut & 10'h3C0);
    wr(8'h4C, 32'h0008_0003);
    wr(`TEREC_OFS_OUTEN, 32'h0000_000F);
    wr(`TEREC_OFS_START, 32'h0000_0008);
    waitpin(8, 1'b0, "comp wave");
    chk("comp pair", {9'h000, !pinOut[8]}, {9'h000, pinOut[9]});
    wr(`TEREC_OFS_FUNC, 32'h0000_0000);
    wr(`TEREC_OFS_START, 32'h0000_0000);
    chs("comp stop", 10'h340, 10'h140);
    wr(`TEREC_OFS_FUNC, 32'h0000_03FF);
    wr(`TEREC_OFS_START, 32'h0000_0008);
    waitpin(8, 1'b1, "comp resume");
    chk("resume pair", {9'h000, !pinOut[8]}, {9'h000, pinOut[9]});
    wr(`TEREC_OFS_FUNC, 32'h0000_0000);
    wr(`TEREC_OFS_START, 32'h0000_0000);
    chs("comp stop 2", 10'h340, 10'h140);
    wr(`TEREC_OFS_MODE, 32'h0000_0000);
    chs("comp exit", 10'h3FF, 10'h000);
  endtask
  task automatic t_rsync();
    wr(`TEREC_OFS_OUTEN, 32'h0000_0000);
    wr(`TEREC_OFS_LEVEL, 32'h0000_0004);
    wr(`TEREC_OFS_MODE, 32'h0000_0005);
    wr(`TEREC_OFS_OUTEN, 32'h0000_000F);
    wr(`TEREC_OFS_FUNC, 32'h0000_03FF);
    wr(`TEREC_OFS_START, 32'h0000_0008);
    waitpin(8, 1'b0, "rsync wave");
    chk("rsync pair", {9'h000, !pinOut[8]}, {9'h000, pinOut[9]});
    wr(`TEREC_OFS_FUNC, 32'h0000_0000);
    wr(`TEREC_OFS_START, 32'h0000_0000);
    chs("rsync stop", 10'h340, 10'h140);
    wr(`TEREC_OFS_MODE, 32'h0000_0004);
    chs("to comp", 10'h040, 10'h000);
    wr(`TEREC_OFS_MODE, 32'h0000_0005);
    wr(`TEREC_OFS_START, 32'h0000_0008);
    wr(`TEREC_OFS_START, 32'h0000_0000);
    wr(`TEREC_OFS_MODE, 32'h0000_0001);
    chs("to pwm1", 10'h300, 10'h200);
  endtask
  ////////////////////////////////////////
  task automatic complete_run();
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // free running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // hang guard, far beyond the 160 or so cycles the run needs
  initial begin
    #50_000;
    failures++;
    complete_run();
  end
  // main sequence
  initial begin
    resetn = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    failures = 0;
    checks = 0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_reset();
    t_normal();
    t_modes();
    t_comp();
    t_rsync();
    complete_run();
  end
endmodule // testbench
